//--- rtl/counter_table_comparator.sv
`timescale 1ns/100ps
`default_nettype none
module counter_table_comparator #(
    parameter int MAX_TARGETS = cmp_pkg::TARGETS_BOARD
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic runMode,
    input wire logic counterEnableSetting,
    input wire cmp_pkg::count_mode_t countMode,
    input wire cmp_pkg::resolution_t encoderResolutionSetting,
    input wire logic countUp,
    input wire logic countDown,
    input wire logic entryWrite,
    input wire logic [5:0] entryIndex,
    input wire logic [31:0] entryValueA,
    input wire logic [31:0] entryValueB,
    input wire logic [15:0] entrySub,
    input wire logic tableRegisterInstruction,
    input wire cmp_pkg::table_cmd_t tableCmd,
    input wire logic [15:0] entryCountBcd,
    input wire logic [31:0] ringValueBcd,
    input wire logic compareControlInstruction,
    input wire cmp_pkg::compare_cmd_t compareCmd,
    output logic signed [31:0] counterValueWords,
    output logic [7:0] auxiliaryFlagArea,
    output logic compareActive,
    output logic tableError,
    output logic intReq,
    output logic [7:0] intSub
);
    localparam int SLOTS = cmp_pkg::RANGE_SLOTS;

    cmp_pkg::cmp_state_t state_q;
    logic signed [31:0] count_q;
    logic dirDown_q;
    logic changed_q;
    logic runPrev_q;
    logic signed [31:0] tgtVal_q [MAX_TARGETS];
    logic [15:0] sub_q [MAX_TARGETS];
    logic okA_q [MAX_TARGETS];
    logic signed [31:0] upper_q [SLOTS];
    logic okB_q [SLOTS];
    logic [5:0] ptr_q;
    logic [5:0] lastIdx_q;
    logic [2:0] scan_q;
    logic signed [31:0] ring_q;
    logic [7:0] auxFlags_q;
    logic tableError_q;
    logic intReq_q;
    logic [7:0] intSub_q;

    logic signed [31:0] decA, decB, decCount, decRing;
    logic validA, validB, validCount, validRing;
    logic signed [31:0] storeA, storeB;
    logic okA, okB;
    logic regOk;
    logic [SLOTS-1:0] inRange, wantsCall;
    logic ringOn;
    logic targetMatch;

    bcd_decode decodeA (.bcd(entryValueA), .value(decA), .valid(validA));
    bcd_decode decodeB (.bcd(entryValueB), .value(decB), .valid(validB));
    bcd_decode decodeCount (.bcd({16'h0, entryCountBcd}), .value(decCount), .valid(validCount));
    bcd_decode decodeRing (.bcd(ringValueBcd), .value(decRing), .valid(validRing));

    function automatic logic in_limits(cmp_pkg::count_mode_t m, logic signed [31:0] v);
        case (m)
            cmp_pkg::MODE_CTR0_DIFF: in_limits = v >= cmp_pkg::CTR0_DIFF_MIN && v <= cmp_pkg::CTR0_DIFF_MAX;
            cmp_pkg::MODE_CTR0_INC: in_limits = v >= cmp_pkg::CTR0_INC_MIN && v <= cmp_pkg::CTR0_INC_MAX;
            cmp_pkg::MODE_LINEAR: in_limits = v >= cmp_pkg::LINEAR_MIN && v <= cmp_pkg::LINEAR_MAX;
            cmp_pkg::MODE_RING: in_limits = v >= cmp_pkg::RING_VAL_MIN && v <= cmp_pkg::RING_VAL_MAX;
            cmp_pkg::MODE_ABS_BCD: in_limits = v >= cmp_pkg::ABS_BCD_MIN && v <= cmp_pkg::ABS_BCD_MAX;
            cmp_pkg::MODE_ABS_ANGLE: in_limits = v >= cmp_pkg::ANGLE_MIN && v <= cmp_pkg::ANGLE_MAX
                                                 && (v % cmp_pkg::ANGLE_STEP) == 0;
            default: in_limits = 1'b0;
        endcase
    endfunction : in_limits

    // rounded degrees times span over a full turn
    function automatic logic signed [31:0] angle_scale(logic signed [31:0] deg, cmp_pkg::resolution_t r);
        int span;
        span = cmp_pkg::RES_8_SPAN;
        case (r)
            cmp_pkg::RES_10: span = cmp_pkg::RES_8_SPAN * 4;
            cmp_pkg::RES_12: span = cmp_pkg::RES_8_SPAN * 16;
            default: span = cmp_pkg::RES_8_SPAN;
        endcase
        angle_scale = 32'((deg * span + cmp_pkg::ANGLE_FULL / 2) / cmp_pkg::ANGLE_FULL);
    endfunction : angle_scale

    function automatic logic sub_ok(logic [15:0] s, logic rangeTable);
        logic digitsOk;
        int num;
        digitsOk = s[11:8] <= 4'h9 && s[7:4] <= 4'h9 && s[3:0] <= 4'h9;
        num = int'(s[11:8]) * 100 + int'(s[7:4]) * 10 + int'(s[3:0]);
        if (rangeTable) begin
            sub_ok = (s == cmp_pkg::SUB_NONE)
                     || (s[15:12] == cmp_pkg::SUB_UP_DIGIT && digitsOk && num <= cmp_pkg::SUB_NUM_MAX);
        end else begin
            sub_ok = (s[15:12] == cmp_pkg::SUB_UP_DIGIT || s[15:12] == cmp_pkg::SUB_DOWN_DIGIT)
                     && digitsOk && num <= cmp_pkg::SUB_NUM_MAX;
        end
    endfunction : sub_ok

    function automatic logic [7:0] sub_number(logic [15:0] s);
        sub_number = 8'(int'(s[11:8]) * 100 + int'(s[7:4]) * 10 + int'(s[3:0]));
    endfunction : sub_number

    // entry decode, check and angle conversion on write
    always_comb begin
        okA = validA && in_limits(countMode, decA);
        okB = validB && in_limits(countMode, decB);
        storeA = decA;
        storeB = decB;
        if (countMode == cmp_pkg::MODE_ABS_ANGLE) begin
            storeA = angle_scale(decA, encoderResolutionSetting);
            storeB = angle_scale(decB, encoderResolutionSetting);
        end
    end

    // registration check across the table
    always_comb begin
        logic rangeTable;
        int maxCount;
        rangeTable = 1'b0;
        maxCount = MAX_TARGETS;
        regOk = 1'b1;
        rangeTable = (tableCmd == cmp_pkg::REG_RANGE_START) || (tableCmd == cmp_pkg::REG_RANGE);
        if (countMode == cmp_pkg::MODE_CTR0_DIFF || countMode == cmp_pkg::MODE_CTR0_INC) begin
            maxCount = cmp_pkg::TARGETS_CTR0;
        end else begin
            maxCount = (MAX_TARGETS < cmp_pkg::TARGETS_BOARD) ? MAX_TARGETS : cmp_pkg::TARGETS_BOARD;
        end
        if (rangeTable) begin
            for (int i = 0; i < SLOTS; i++) begin
                regOk = regOk && okA_q[i] && okB_q[i] && sub_ok(sub_q[i], 1'b1);
            end
        end else begin
            regOk = validCount && decCount >= cmp_pkg::COUNT_MIN && decCount <= maxCount;
            for (int i = 0; i < MAX_TARGETS; i++) begin
                if (i < decCount) begin
                    regOk = regOk && okA_q[i] && sub_ok(sub_q[i], 1'b0);
                end
            end
        end
        if (countMode == cmp_pkg::MODE_RING) begin
            regOk = regOk && validRing && decRing >= 0 && decRing <= cmp_pkg::RING_MAX;
        end
    end

    // table storage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < MAX_TARGETS; i++) begin
                tgtVal_q[i] <= 32'sh0;
                sub_q[i] <= cmp_pkg::SUB_NONE;
                okA_q[i] <= 1'b0;
            end
            for (int i = 0; i < SLOTS; i++) begin
                upper_q[i] <= 32'sh0;
                okB_q[i] <= 1'b0;
            end
        end else if (entryWrite && int'(entryIndex) < MAX_TARGETS) begin
            tgtVal_q[entryIndex] <= storeA;
            sub_q[entryIndex] <= entrySub;
            okA_q[entryIndex] <= okA;
            if (int'(entryIndex) < SLOTS) begin
                upper_q[entryIndex[2:0]] <= storeB;
                okB_q[entryIndex[2:0]] <= okB;
            end
        end
    end

    assign ringOn = (countMode == cmp_pkg::MODE_RING) && (ring_q != 32'sh0);

    // present count value
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_q <= 32'sh0;
            dirDown_q <= 1'b0;
            changed_q <= 1'b0;
            runPrev_q <= 1'b0;
        end else begin
            runPrev_q <= runMode;
            changed_q <= 1'b0;
            if ((runMode && !runPrev_q)
                || (compareControlInstruction && compareCmd == cmp_pkg::CTL_RESET_PV)) begin
                count_q <= 32'sh0;
            end else if (runMode && counterEnableSetting && (countUp != countDown)) begin
                changed_q <= 1'b1;
                dirDown_q <= countDown;
                if (countUp) begin
                    count_q <= (ringOn && count_q >= ring_q - 32'sh1) ? 32'sh0 : count_q + 32'sh1;
                end else begin
                    count_q <= (ringOn && count_q <= 32'sh0) ? ring_q - 32'sh1 : count_q - 32'sh1;
                end
            end
        end
    end

    // table state: registration, start, stop, halt
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= cmp_pkg::ST_NO_TABLE;
            lastIdx_q <= 6'h0;
            ring_q <= 32'sh0;
            tableError_q <= 1'b0;
        end else begin
            tableError_q <= 1'b0;
            if (!runMode) begin
                state_q <= cmp_pkg::ST_NO_TABLE;
            end else if (tableRegisterInstruction) begin
                if (!regOk) begin
                    state_q <= cmp_pkg::ST_NO_TABLE;
                    tableError_q <= 1'b1;
                end else begin
                    lastIdx_q <= 6'(decCount - 32'sd1);
                    ring_q <= decRing;
                    case (tableCmd)
                        cmp_pkg::REG_TARGET_START: state_q <= cmp_pkg::ST_TARGET;
                        cmp_pkg::REG_RANGE_START: state_q <= cmp_pkg::ST_RANGE;
                        default: state_q <= cmp_pkg::ST_STOPPED;
                    endcase
                end
            end else if (compareControlInstruction && state_q != cmp_pkg::ST_NO_TABLE) begin
                case (compareCmd)
                    cmp_pkg::CTL_START: begin
                        if (tableCmd == cmp_pkg::REG_RANGE || tableCmd == cmp_pkg::REG_RANGE_START) begin
                            state_q <= cmp_pkg::ST_RANGE;
                        end else begin
                            state_q <= cmp_pkg::ST_TARGET;
                        end
                    end
                    cmp_pkg::CTL_STOP: state_q <= cmp_pkg::ST_STOPPED;
                    default: state_q <= state_q;
                endcase
            end
        end
    end

    // target walk
    assign targetMatch = state_q == cmp_pkg::ST_TARGET && changed_q
                         && count_q == tgtVal_q[ptr_q]
                         && ((sub_q[ptr_q][15:12] == cmp_pkg::SUB_DOWN_DIGIT) == dirDown_q);

    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : gSlot
            range_slot slot (
                .enable(state_q == cmp_pkg::ST_RANGE),
                .count(count_q),
                .lower(tgtVal_q[g]),
                .upper(upper_q[g]),
                .sub(sub_q[g]),
                .inRange(inRange[g]),
                .wantsCall(wantsCall[g])
            );
        end
    endgenerate

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ptr_q <= 6'h0;
        end else if (state_q != cmp_pkg::ST_TARGET || tableRegisterInstruction) begin
            ptr_q <= 6'h0;
        end else if (targetMatch) begin
            ptr_q <= (ptr_q >= lastIdx_q) ? 6'h0 : ptr_q + 6'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scan_q <= 3'h0;
            auxFlags_q <= 8'h00;
        end else begin
            scan_q <= scan_q + 3'h1;
            auxFlags_q <= inRange;
        end
    end

    // interrupt request pulses
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            intReq_q <= 1'b0;
            intSub_q <= 8'h00;
        end else begin
            intReq_q <= 1'b0;
            if (targetMatch) begin
                intReq_q <= 1'b1;
                intSub_q <= sub_number(sub_q[ptr_q]);
            end else if (wantsCall[scan_q]) begin
                intReq_q <= 1'b1;
                intSub_q <= sub_number(sub_q[scan_q]);
            end
        end
    end

    assign counterValueWords = count_q;
    assign auxiliaryFlagArea = auxFlags_q;
    assign compareActive = (state_q == cmp_pkg::ST_TARGET) || (state_q == cmp_pkg::ST_RANGE);
    assign tableError = tableError_q;
    assign intReq = intReq_q;
    assign intSub = intSub_q;

endmodule : counter_table_comparator
`default_nettype wire

//--- rtl/cmp_pkg.sv
package cmp_pkg;

    localparam int VALUE_W = 32;
    localparam int SUB_W = 16;
    localparam int TARGETS_CTR0 = 16;
    localparam int TARGETS_BOARD = 48;
    localparam int RANGE_SLOTS = 8;
    localparam int COUNT_MIN = 1;
    localparam int RING_MAX = 65000;
    localparam int SUB_NUM_MAX = 255;

    // signed BCD marker in the most significant digit
    localparam logic [3:0] NEG_DIGIT = 4'hF;
    // subroutine code prefix that selects the decrementing direction
    localparam logic [3:0] SUB_DOWN_DIGIT = 4'hF;
    localparam logic [3:0] SUB_UP_DIGIT = 4'h0;
    localparam logic [15:0] SUB_NONE = 16'hFFFF;

    // accepted comparison values per counting mode
    localparam int CTR0_DIFF_MIN = -32768;
    localparam int CTR0_DIFF_MAX = 32767;
    localparam int CTR0_INC_MIN = 0;
    localparam int CTR0_INC_MAX = 65535;
    localparam int LINEAR_MIN = -8388607;
    localparam int LINEAR_MAX = 8388608;
    localparam int RING_VAL_MIN = 0;
    localparam int RING_VAL_MAX = 64999;
    localparam int ABS_BCD_MIN = 0;
    localparam int ABS_BCD_MAX = 4095;
    localparam int ANGLE_MIN = 0;
    localparam int ANGLE_MAX = 355;
    localparam int ANGLE_STEP = 5;
    localparam int ANGLE_FULL = 360;
    localparam int RES_8_SPAN = 256;

    typedef enum logic [2:0] {
        MODE_CTR0_DIFF = 3'b000,
        MODE_CTR0_INC = 3'b001,
        MODE_LINEAR = 3'b010,
        MODE_RING = 3'b011,
        MODE_ABS_BCD = 3'b100,
        MODE_ABS_ANGLE = 3'b101
    } count_mode_t;

    typedef enum logic [1:0] {
        RES_8 = 2'b00,
        RES_10 = 2'b01,
        RES_12 = 2'b10
    } resolution_t;

    typedef enum logic [1:0] {
        REG_TARGET_START = 2'b00,
        REG_RANGE_START = 2'b01,
        REG_TARGET = 2'b10,
        REG_RANGE = 2'b11
    } table_cmd_t;

    typedef enum logic [1:0] {
        CTL_START = 2'b00,
        CTL_STOP = 2'b01,
        CTL_RESET_PV = 2'b10,
        CTL_NONE = 2'b11
    } compare_cmd_t;

    typedef enum logic [1:0] {
        ST_NO_TABLE = 2'b00,
        ST_STOPPED = 2'b01,
        ST_TARGET = 2'b10,
        ST_RANGE = 2'b11
    } cmp_state_t;

endpackage : cmp_pkg

//--- rtl/bcd_decode.sv
`timescale 1ns/100ps
`default_nettype none
module bcd_decode (
    input wire logic [31:0] bcd,
    output logic signed [31:0] value,
    output logic valid
);
    logic [31:0] acc;
    logic neg;
    always_comb begin
        acc = 32'h0;
        valid = 1'b1;
        neg = (bcd[31:28] == cmp_pkg::NEG_DIGIT);
        for (int i = 7; i >= 0; i--) begin
            if (i == 7 && neg) begin
                acc = 32'h0;
            end else begin
                if (bcd[i*4 +: 4] > 4'h9) begin
                    valid = 1'b0;
                end
                acc = 32'(acc * 32'd10) + {28'h0, bcd[i*4 +: 4]};
            end
        end
        value = neg ? -$signed(acc) : $signed(acc);
    end
endmodule : bcd_decode
`default_nettype wire

//--- rtl/range_slot.sv
`timescale 1ns/100ps
`default_nettype none
module range_slot (
    input wire logic enable,
    input wire logic signed [31:0] count,
    input wire logic signed [31:0] lower,
    input wire logic signed [31:0] upper,
    input wire logic [15:0] sub,
    output logic inRange,
    output logic wantsCall
);
    always_comb begin
        inRange = enable && (count >= lower) && (count <= upper);
        wantsCall = inRange && (sub != cmp_pkg::SUB_NONE);
    end
endmodule : range_slot
`default_nettype wire

//--- tb/counter_table_comparator_properties.sv
`timescale 1ns/100ps
`default_nettype none
module counter_table_comparator_properties #(
    parameter int MAX_TARGETS = 48
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic runMode,
    input wire logic counterEnableSetting,
    input wire cmp_pkg::count_mode_t countMode,
    input wire logic countUp,
    input wire logic countDown,
    input wire logic tableRegisterInstruction,
    input wire cmp_pkg::table_cmd_t tableCmd,
    input wire logic compareControlInstruction,
    input wire cmp_pkg::compare_cmd_t compareCmd,
    input wire logic signed [31:0] counterValueWords,
    input wire logic [7:0] auxiliaryFlagArea,
    input wire logic compareActive,
    input wire logic tableError,
    input wire logic intReq,
    input wire logic [7:0] intSub
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // linear counting in a settled run with no control command
    sequence settled;
        runMode && $past(runMode) && $past(runMode, 2) && counterEnableSetting
            && !compareControlInstruction && countMode == cmp_pkg::MODE_LINEAR;
    endsequence
    sequence upStep;
        settled ##0 (countUp && !countDown);
    endsequence
    sequence downStep;
        settled ##0 (countDown && !countUp);
    endsequence
    sequence noStep;
        settled ##0 (countUp == countDown);
    endsequence

    chk_count_up: assert property (upStep |=> counterValueWords == $past(counterValueWords) + 1)
        else $error("count did not step up");
    chk_count_down: assert property (downStep |=> counterValueWords == $past(counterValueWords) - 1)
        else $error("count did not step down");
    chk_count_hold: assert property (noStep |=> $stable(counterValueWords))
        else $error("count moved without a step");
    chk_count_clear: assert property (compareControlInstruction && runMode
        && compareCmd == cmp_pkg::CTL_RESET_PV && countUp == countDown |=> counterValueWords == 0)
        else $error("count not cleared by command");
    chk_stop_cmd: assert property (compareControlInstruction && compareCmd == cmp_pkg::CTL_STOP
        && !tableRegisterInstruction |=> !compareActive)
        else $error("comparison still active after stop");
    chk_halt_drop: assert property (!runMode |=> !compareActive)
        else $error("comparison active while halted");
    chk_error_drop: assert property (tableError |-> !compareActive)
        else $error("comparison active after failed registration");
    chk_start_active: assert property (tableRegisterInstruction && runMode
        && !compareControlInstruction
        && tableCmd inside {cmp_pkg::REG_TARGET_START, cmp_pkg::REG_RANGE_START}
        |=> compareActive || tableError)
        else $error("start variant did not start comparison");
    chk_register_only: assert property (tableRegisterInstruction && runMode
        && !compareControlInstruction
        && tableCmd inside {cmp_pkg::REG_TARGET, cmp_pkg::REG_RANGE} |=> !compareActive)
        else $error("plain registration started comparison");
    chk_int_quiet: assert property ((!compareActive) [*3] |=> !intReq)
        else $error("call request without comparison");
    chk_flags_off: assert property ((!compareActive) [*2] |=> auxiliaryFlagArea == 8'h00)
        else $error("range flags set without comparison");
    chk_sub_hold: assert property ($changed(intSub) |-> intReq)
        else $error("subroutine number changed without request");
endmodule : counter_table_comparator_properties

bind counter_table_comparator counter_table_comparator_properties #(
    .MAX_TARGETS(MAX_TARGETS)
) i_counter_table_comparator_properties (
    .clk, .reset, .runMode, .counterEnableSetting, .countMode, .countUp, .countDown,
    .tableRegisterInstruction, .tableCmd, .compareControlInstruction, .compareCmd,
    .counterValueWords, .auxiliaryFlagArea, .compareActive, .tableError, .intReq, .intSub
);
`default_nettype wire

//--- tb/counter_table_comparator_tb.sv
`timescale 1ns/100ps
`default_nettype none
module counter_table_comparator_tb;
    logic clk, reset, runMode, counterEnableSetting, countUp, countDown, entryWrite;
    logic tableRegisterInstruction, compareControlInstruction, compareActive, tableError, intReq;
    cmp_pkg::count_mode_t countMode;
    cmp_pkg::resolution_t encoderResolutionSetting;
    cmp_pkg::table_cmd_t tableCmd;
    cmp_pkg::compare_cmd_t compareCmd;
    logic [5:0] entryIndex;
    logic [31:0] entryValueA, entryValueB, ringValueBcd;
    logic [15:0] entrySub, entryCountBcd;
    logic signed [31:0] counterValueWords;
    logic [7:0] auxiliaryFlagArea, intSub;
    int mismatches, checkCount, cnt, ptr, nTgt, ring;
    int tv[48], ts[48], lo[8], hi[8];
    bit tdn[48];
    bit tgtOn, rangeOn;

    counter_table_comparator i_counter_table_comparator (
        .clk, .reset, .runMode, .counterEnableSetting, .countMode, .encoderResolutionSetting,
        .countUp, .countDown, .entryWrite, .entryIndex, .entryValueA, .entryValueB, .entrySub,
        .tableRegisterInstruction, .tableCmd, .entryCountBcd, .ringValueBcd,
        .compareControlInstruction, .compareCmd, .counterValueWords, .auxiliaryFlagArea,
        .compareActive, .tableError, .intReq, .intSub
    );

    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    task automatic conclude();
        if (mismatches == 0 && checkCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic cmpv(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : cmpv

    // signed bcd, top digit F when negative
    function automatic logic [31:0] bcd(input int v);
        int a;
        logic [31:0] r;
        a = (v < 0) ? -v : v;
        r = 32'h0;
        for (int i = 0; i < 7; i++) begin
            r[4*i +: 4] = 4'(a % 10);
            a = a / 10;
        end
        if (v < 0) r[31:28] = 4'hF;
        return r;
    endfunction : bcd

    function automatic logic [15:0] subc(input int k, input bit dn);
        logic [31:0] r;
        r = bcd(k);
        return {dn ? 4'hF : 4'h0, r[11:0]};
    endfunction : subc

    function automatic logic [7:0] flagsExp();
        logic [7:0] f;
        for (int i = 0; i < 8; i++) f[i] = (cnt >= lo[i] && cnt <= hi[i]);
        return f;
    endfunction : flagsExp

    // caller lowers entryWrite after the last write
    task automatic wr(input int i, input int a, input int b, input logic [15:0] s);
        entryWrite = 1;
        entryIndex = 6'(i);
        entryValueA = bcd(a);
        entryValueB = bcd(b);
        entrySub = s;
        @(negedge clk);
    endtask : wr

    task automatic tgt(input int i, input int v, input int k, input bit dn);
        tv[i] = v;
        ts[i] = k;
        tdn[i] = dn;
        wr(i, v, v, subc(k, dn));
    endtask : tgt

    task automatic reg_tbl(input cmp_pkg::table_cmd_t c, input int num, input bit err);
        logic [31:0] b;
        b = bcd(num);
        @(negedge clk);
        tableCmd = c;
        entryCountBcd = b[15:0];
        tableRegisterInstruction = 1;
        @(negedge clk);
        tableRegisterInstruction = 0;
        tgtOn = !err && c == cmp_pkg::REG_TARGET_START;
        rangeOn = !err && c == cmp_pkg::REG_RANGE_START;
        ptr = 0;
        nTgt = num;
        cmpv("tableError", err, tableError);
        cmpv("compareActive", tgtOn | rangeOn, compareActive);
    endtask : reg_tbl

    task automatic ctl(input cmp_pkg::compare_cmd_t c);
        @(negedge clk);
        compareCmd = c;
        compareControlInstruction = 1;
        @(negedge clk);
        compareControlInstruction = 0;
        if (c == cmp_pkg::CTL_RESET_PV) cnt = 0;
        if (c == cmp_pkg::CTL_STOP) {tgtOn, rangeOn} = 2'h0;
        if (c == cmp_pkg::CTL_START) {tgtOn, rangeOn} = {!tableCmd[0], tableCmd[0]};
        cmpv("compareActive", tgtOn | rangeOn, compareActive);
        cmpv("count", cnt, counterValueWords);
    endtask : ctl

    // one step every two cycles, model predicts the call
    task automatic steps(input int num, input bit up);
        bit fire;
        int es;
        for (int s = 0; s < num; s++) begin
            fire = 0;
            es = 0;
            countUp = up;
            countDown = !up;
            cnt = up ? cnt + 1 : cnt - 1;
            if (ring > 0) cnt = (cnt + ring) % ring;
            if (tgtOn && cnt == tv[ptr] && tdn[ptr] == !up) begin
                fire = 1;
                es = ts[ptr];
                ptr = (ptr + 1) % nTgt;
            end
            @(negedge clk);
            countUp = 0;
            countDown = 0;
            cmpv("count", cnt, counterValueWords);
            @(negedge clk);
            if (!rangeOn) cmpv("intReq", fire, intReq);
            if (fire) cmpv("intSub", es, intSub);
            cmpv("flags", rangeOn ? flagsExp() : 8'h00, auxiliaryFlagArea);
        end
    endtask : steps

    task automatic wait_call(input int es);
        int k;
        k = 0;
        while (intReq !== 1'b1 && k < 16) begin
            @(negedge clk);
            k++;
        end
        cmpv("rangeCall", 1, intReq);
        cmpv("intSub", es, intSub);
        @(negedge clk);
    endtask : wait_call

    initial begin
        #500000;
        mismatches++;
        conclude();
    end

    initial begin
        int v;
        void'($urandom(50547));
        reset = 1;
        runMode = 1;
        counterEnableSetting = 1;
        {countUp, countDown, entryWrite, tableRegisterInstruction, compareControlInstruction} = 5'h00;
        {entryValueA, entryValueB, ringValueBcd} = 96'h0;
        {entryIndex, entrySub, entryCountBcd} = 38'h0;
        countMode = cmp_pkg::MODE_CTR0_INC;
        encoderResolutionSetting = cmp_pkg::RES_8;
        tableCmd = cmp_pkg::REG_TARGET;
        compareCmd = cmp_pkg::CTL_NONE;
        repeat (6) @(negedge clk);
        reset = 0;
        cmpv("count", 0, counterValueWords);
        cmpv("compareActive", 0, compareActive);
        for (int i = 0; i < 17; i++) tgt(i, 2 * i + 1, i, 0);
        entryWrite = 0;
        reg_tbl(cmp_pkg::REG_TARGET_START, 17, 1);
        reg_tbl(cmp_pkg::REG_TARGET_START, 0, 1);
        reg_tbl(cmp_pkg::REG_TARGET, 16, 0);
        steps(3, 1);
        ctl(cmp_pkg::CTL_RESET_PV);
        ctl(cmp_pkg::CTL_START);
        steps(34, 1);
        ctl(cmp_pkg::CTL_RESET_PV);
        steps(1, 1);
        countMode = cmp_pkg::MODE_LINEAR;
        v = -20;
        for (int i = 0; i < 48; i++) begin
            v = v + 1 + int'($urandom % 3);
            tgt(i, v, int'($urandom % 256), 0);
        end
        entryWrite = 0;
        reg_tbl(cmp_pkg::REG_TARGET_START, 49, 1);
        reg_tbl(cmp_pkg::REG_TARGET_START, 48, 0);
        ctl(cmp_pkg::CTL_RESET_PV);
        steps(25, 0);
        steps(175, 1);
        tgt(0, cnt - 2, int'($urandom % 256), 1);
        tgt(1, cnt - 4, int'($urandom % 256), 0);
        entryWrite = 0;
        reg_tbl(cmp_pkg::REG_TARGET_START, 2, 0);
        steps(5, 0);
        steps(1, 1);
        for (int i = 0; i < 8; i++) begin
            lo[i] = cnt + int'($urandom % 10);
            hi[i] = lo[i] + int'($urandom % 6);
            wr(i, lo[i], hi[i], i == 2 ? subc(42, 0) : cmp_pkg::SUB_NONE);
        end
        entryWrite = 0;
        reg_tbl(cmp_pkg::REG_RANGE_START, 8, 0);
        steps(20, 1);
        steps(cnt - lo[2], 0);
        wait_call(42);
        wait_call(42);
        ctl(cmp_pkg::CTL_STOP);
        repeat (3) @(negedge clk);
        cmpv("flags", 8'h00, auxiliaryFlagArea);
        ctl(cmp_pkg::CTL_START);
        steps(1, 1);
        reg_tbl(cmp_pkg::REG_TARGET_START, 0, 1);
        reg_tbl(cmp_pkg::REG_RANGE_START, 8, 0);
        runMode = 0;
        repeat (2) @(negedge clk);
        rangeOn = 0;
        cmpv("compareActive", 0, compareActive);
        runMode = 1;
        repeat (3) @(negedge clk);
        cnt = 0;
        cmpv("count", cnt, counterValueWords);
        countMode = cmp_pkg::MODE_CTR0_DIFF;
        tgt(0, -32769, 1, 1);
        entryWrite = 0;
        reg_tbl(cmp_pkg::REG_TARGET_START, 1, 1);
        countMode = cmp_pkg::MODE_ABS_ANGLE;
        tgt(1, 47, 1, 0);
        tgt(0, 45, 7, 0);
        entryWrite = 0;
        reg_tbl(cmp_pkg::REG_TARGET_START, 2, 1);
        tv[0] = 32;
        reg_tbl(cmp_pkg::REG_TARGET_START, 1, 0);
        steps(33, 1);
        countMode = cmp_pkg::MODE_RING;
        tgt(0, 2, 5, 0);
        entryWrite = 0;
        ringValueBcd = bcd(65001);
        reg_tbl(cmp_pkg::REG_TARGET_START, 1, 1);
        ringValueBcd = bcd(10);
        reg_tbl(cmp_pkg::REG_TARGET_START, 1, 0);
        ctl(cmp_pkg::CTL_RESET_PV);
        ring = 10;
        steps(13, 1);
        steps(4, 0);
        conclude();
    end
endmodule : counter_table_comparator_tb
`default_nettype wire
